//--- common/bsdr_defines.vh
`ifndef BSDR_DEFINES_VH
`define BSDR_DEFINES_VH

// chain geometry and instruction codes
`define BSDR_CHAIN_LEN   98
`define BSDR_IR_W        3
`define BSDR_IR_EXTEST   3'h0
`define BSDR_IR_SAMPLE   3'h4
`define BSDR_IR_IDCODE   3'h6
`define BSDR_IR_BYPASS   3'h7

// single cells
`define BSDR_POS_BUS_DIR 7'h10
`define BSDR_POS_INT     7'h32
`define BSDR_POS_ACK     7'h33
`define BSDR_POS_ACK_OE  7'h34
`define BSDR_POS_MODE1   7'h21
`define BSDR_POS_WR      7'h35
`define BSDR_POS_RD      7'h36
`define BSDR_POS_ALE     7'h37
`define BSDR_POS_CS      7'h38

// per-channel cells, channel 0 to 3
`define BSDR_POS_RXC0    7'h1c
`define BSDR_POS_RXC1    7'h14
`define BSDR_POS_RXC2    7'h2e
`define BSDR_POS_RXC3    7'h26
`define BSDR_POS_RXP0    7'h1d
`define BSDR_POS_RXP1    7'h15
`define BSDR_POS_RXP2    7'h2c
`define BSDR_POS_RXP3    7'h24
`define BSDR_POS_RXN0    7'h1e
`define BSDR_POS_RXN1    7'h16
`define BSDR_POS_RXN2    7'h2b
`define BSDR_POS_RXN3    7'h23
`define BSDR_POS_RXOE0   7'h1f
`define BSDR_POS_RXOE1   7'h17
`define BSDR_POS_RXOE2   7'h2d
`define BSDR_POS_RXOE3   7'h25
`define BSDR_POS_LSIG0   7'h20
`define BSDR_POS_LSIG1   7'h18
`define BSDR_POS_LSIG2   7'h2a
`define BSDR_POS_LSIG3   7'h22
`define BSDR_POS_TXC0    7'h19
`define BSDR_POS_TXC1    7'h11
`define BSDR_POS_TXC2    7'h31
`define BSDR_POS_TXC3    7'h29
`define BSDR_POS_TXP0    7'h1a
`define BSDR_POS_TXP1    7'h12
`define BSDR_POS_TXP2    7'h30
`define BSDR_POS_TXP3    7'h28
`define BSDR_POS_TXN0    7'h1b
`define BSDR_POS_TXN1    7'h13
`define BSDR_POS_TXN2    7'h2f
`define BSDR_POS_TXN3    7'h27

// reset values: update latches float everything, chain clear
`define BSDR_UPD_RST     98'h3_ffff_ffff_ffff_ffff_ffff_ffff
`define BSDR_CHAIN_RST   98'h0

`endif

//--- logic/bsdr_sync.v
`timescale 1ns/1ps

// two-stage synchroniser for a bundle of asynchronous levels
module bsdr_sync #(
  parameter WIDTH = 1
) (
  input  wire             i_clk,
  input  wire             i_rstn,
  input  wire [WIDTH-1:0] i_d,
  output wire [WIDTH-1:0] o_q
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_d;
      sync_reg <= meta_reg;
    end
  end

  assign o_q = sync_reg;

endmodule // bsdr_sync

//--- logic/bsdr_top.v
`timescale 1ns/1ps
`include "bsdr_defines.vh"

module bsdr_top #(
  parameter CHAIN_LEN = `BSDR_CHAIN_LEN,
  parameter BUS_W     = 8,
  parameter NUM_CH    = 4
) (
  input  wire                  I_CORE_CLK,
  input  wire                  I_RSTN,
  input  wire                  I_TCK,
  input  wire                  I_TDI,
  input  wire                  I_CAPTURE_DR,
  input  wire                  I_SHIFT_DR,
  input  wire                  I_UPDATE_DR,
  input  wire [`BSDR_IR_W-1:0] I_INSTR,
  output wire                  O_TDO,
  output wire                  O_TDO_OE,
  output wire                  O_CHAIN_SEL,
  input  wire [BUS_W-1:0]      I_BUS_PIN,
  input  wire [BUS_W-1:0]      I_CORE_BUS_OUT,
  input  wire                  I_CORE_BUS_OE,
  output wire [BUS_W-1:0]      O_BUS_OUT,
  output wire                  O_BUS_OE,
  input  wire [NUM_CH-1:0]     I_TX_CLK_PIN,
  input  wire [NUM_CH-1:0]     I_TX_POS_PIN,
  input  wire [NUM_CH-1:0]     I_TX_NEG_PIN,
  input  wire [NUM_CH-1:0]     I_CORE_RX_CLK,
  input  wire [NUM_CH-1:0]     I_CORE_RX_POS,
  input  wire [NUM_CH-1:0]     I_CORE_RX_NEG,
  input  wire [NUM_CH-1:0]     I_CORE_RX_OE,
  input  wire [NUM_CH-1:0]     I_CORE_LOSS_OF_SIGNAL,
  output wire [NUM_CH-1:0]     O_RX_CLK,
  output wire [NUM_CH-1:0]     O_RX_POS,
  output wire [NUM_CH-1:0]     O_RX_NEG,
  output wire [NUM_CH-1:0]     O_RX_OE,
  output wire [NUM_CH-1:0]     O_LOSS_OF_SIGNAL,
  input  wire                  I_CORE_INT_N,
  input  wire                  I_CORE_ACK,
  input  wire                  I_CORE_ACK_OE,
  output wire                  O_INT_N,
  output wire                  O_ACK,
  output wire                  O_ACK_OE,
  input  wire                  I_MODE1_PIN,
  input  wire                  I_WR_STROBE_PIN,
  input  wire                  I_RD_STROBE_PIN,
  input  wire                  I_ADDR_LATCH_PIN,
  input  wire                  I_CHIP_SEL_PIN
);

  // cell kinds for the per-channel position lookup
  localparam [2:0] K_RXC  = 3'h0;
  localparam [2:0] K_RXP  = 3'h1;
  localparam [2:0] K_RXN  = 3'h2;
  localparam [2:0] K_RXOE = 3'h3;
  localparam [2:0] K_LSIG = 3'h4;
  localparam [2:0] K_TXC  = 3'h5;
  localparam [2:0] K_TXP  = 3'h6;
  localparam [2:0] K_TXN  = 3'h7;

  localparam SYNC_W = 8 + BUS_W + 3*NUM_CH + 5;

  // chain position of a per-channel cell; channels are not laid out in order
  function [6:0] cell_pos;
    input [2:0] kind;
    input [1:0] ch;
    begin
      case ({kind, ch})
        {K_RXC, 2'd0}:  cell_pos = `BSDR_POS_RXC0;
        {K_RXC, 2'd1}:  cell_pos = `BSDR_POS_RXC1;
        {K_RXC, 2'd2}:  cell_pos = `BSDR_POS_RXC2;
        {K_RXC, 2'd3}:  cell_pos = `BSDR_POS_RXC3;
        {K_RXP, 2'd0}:  cell_pos = `BSDR_POS_RXP0;
        {K_RXP, 2'd1}:  cell_pos = `BSDR_POS_RXP1;
        {K_RXP, 2'd2}:  cell_pos = `BSDR_POS_RXP2;
        {K_RXP, 2'd3}:  cell_pos = `BSDR_POS_RXP3;
        {K_RXN, 2'd0}:  cell_pos = `BSDR_POS_RXN0;
        {K_RXN, 2'd1}:  cell_pos = `BSDR_POS_RXN1;
        {K_RXN, 2'd2}:  cell_pos = `BSDR_POS_RXN2;
        {K_RXN, 2'd3}:  cell_pos = `BSDR_POS_RXN3;
        {K_RXOE, 2'd0}: cell_pos = `BSDR_POS_RXOE0;
        {K_RXOE, 2'd1}: cell_pos = `BSDR_POS_RXOE1;
        {K_RXOE, 2'd2}: cell_pos = `BSDR_POS_RXOE2;
        {K_RXOE, 2'd3}: cell_pos = `BSDR_POS_RXOE3;
        {K_LSIG, 2'd0}: cell_pos = `BSDR_POS_LSIG0;
        {K_LSIG, 2'd1}: cell_pos = `BSDR_POS_LSIG1;
        {K_LSIG, 2'd2}: cell_pos = `BSDR_POS_LSIG2;
        {K_LSIG, 2'd3}: cell_pos = `BSDR_POS_LSIG3;
        {K_TXC, 2'd0}:  cell_pos = `BSDR_POS_TXC0;
        {K_TXC, 2'd1}:  cell_pos = `BSDR_POS_TXC1;
        {K_TXC, 2'd2}:  cell_pos = `BSDR_POS_TXC2;
        {K_TXC, 2'd3}:  cell_pos = `BSDR_POS_TXC3;
        {K_TXP, 2'd0}:  cell_pos = `BSDR_POS_TXP0;
        {K_TXP, 2'd1}:  cell_pos = `BSDR_POS_TXP1;
        {K_TXP, 2'd2}:  cell_pos = `BSDR_POS_TXP2;
        {K_TXP, 2'd3}:  cell_pos = `BSDR_POS_TXP3;
        {K_TXN, 2'd0}:  cell_pos = `BSDR_POS_TXN0;
        {K_TXN, 2'd1}:  cell_pos = `BSDR_POS_TXN1;
        {K_TXN, 2'd2}:  cell_pos = `BSDR_POS_TXN2;
        {K_TXN, 2'd3}:  cell_pos = `BSDR_POS_TXN3;
        default:        cell_pos = 7'h00;
      endcase
    end
  endfunction

  wire [SYNC_W-1:0]     sync_q;
  wire                  tck_s;
  wire                  tdi_s;
  wire                  capture_s;
  wire                  shift_s;
  wire                  update_s;
  wire [`BSDR_IR_W-1:0] instr_s;
  wire [BUS_W-1:0]      bus_pin_s;
  wire [NUM_CH-1:0]     tx_clk_s;
  wire [NUM_CH-1:0]     tx_pos_s;
  wire [NUM_CH-1:0]     tx_neg_s;
  wire                  mode1_s;
  wire                  wr_s;
  wire                  rd_s;
  wire                  ale_s;
  wire                  cs_s;

  // every pin and the tap levels cross in one bundle, so they stay aligned
  bsdr_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_d    ({I_TCK, I_TDI, I_CAPTURE_DR, I_SHIFT_DR, I_UPDATE_DR, I_INSTR,
              I_BUS_PIN, I_TX_CLK_PIN, I_TX_POS_PIN, I_TX_NEG_PIN,
              I_MODE1_PIN, I_WR_STROBE_PIN, I_RD_STROBE_PIN,
              I_ADDR_LATCH_PIN, I_CHIP_SEL_PIN}),
    .o_q    (sync_q)
  );

  assign {tck_s, tdi_s, capture_s, shift_s, update_s, instr_s,
          bus_pin_s, tx_clk_s, tx_pos_s, tx_neg_s,
          mode1_s, wr_s, rd_s, ale_s, cs_s} = sync_q;

  reg                 tck_prev_reg;
  reg [CHAIN_LEN-1:0] chain_reg;
  reg [CHAIN_LEN-1:0] chain_next;
  reg [CHAIN_LEN-1:0] cap_vec;
  reg                 bypass_reg;
  reg                 bypass_next;
  reg [CHAIN_LEN-1:0] upd_reg;
  reg [CHAIN_LEN-1:0] upd_next;
  reg                 tdo_reg;
  reg                 tdo_next;
  reg                 tdo_oe_reg;
  reg                 tdo_oe_next;
  reg                 chain_sel_reg;
  reg [BUS_W-1:0]     bus_out_reg;
  reg                 bus_oe_reg;
  reg                 int_n_reg;
  reg                 ack_reg;
  reg                 ack_oe_reg;

  // tck edges seen from the core clock; tck must be slower than clk/4
  wire tck_rise = tck_s & ~tck_prev_reg;
  wire tck_fall = ~tck_s & tck_prev_reg;

  wire extest_on = (instr_s == `BSDR_IR_EXTEST);
  wire chain_on  = extest_on | (instr_s == `BSDR_IR_SAMPLE);

  // parallel capture image of the pins
  always @* begin : cap_build
    integer k;
    k       = 0;
    cap_vec = chain_reg;
    for (k = 0; k < BUS_W; k = k + 1) begin
      cap_vec[2*k+1] = bus_pin_s[k];
    end
    for (k = 0; k < NUM_CH; k = k + 1) begin
      cap_vec[cell_pos(K_TXC, k[1:0])]  = tx_clk_s[k];
      cap_vec[cell_pos(K_TXP, k[1:0])]  = tx_pos_s[k];
      cap_vec[cell_pos(K_TXN, k[1:0])]  = tx_neg_s[k];
      cap_vec[cell_pos(K_RXC, k[1:0])]  = I_CORE_RX_CLK[k];
      cap_vec[cell_pos(K_RXP, k[1:0])]  = I_CORE_RX_POS[k];
      cap_vec[cell_pos(K_RXN, k[1:0])]  = I_CORE_RX_NEG[k];
      cap_vec[cell_pos(K_LSIG, k[1:0])] = I_CORE_LOSS_OF_SIGNAL[k];
    end
    cap_vec[`BSDR_POS_INT]   = I_CORE_INT_N;
    cap_vec[`BSDR_POS_ACK]   = I_CORE_ACK;
    cap_vec[`BSDR_POS_MODE1] = mode1_s;
    cap_vec[`BSDR_POS_WR]    = wr_s;
    cap_vec[`BSDR_POS_RD]    = rd_s;
    cap_vec[`BSDR_POS_ALE]   = ale_s;
    cap_vec[`BSDR_POS_CS]    = cs_s;
  end

  // scan engine: capture and shift on tck rise, tdo and update on tck fall
  always @* begin
    chain_next  = chain_reg;
    bypass_next = bypass_reg;
    upd_next    = upd_reg;
    tdo_next    = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (tck_rise) begin
      if (capture_s) begin
        bypass_next = 1'b0;
        if (chain_on) begin
          chain_next = cap_vec;
        end
      end else if (shift_s) begin
        bypass_next = tdi_s;
        if (chain_on) begin
          chain_next = {tdi_s, chain_reg[CHAIN_LEN-1:1]};
        end
      end
    end
    if (tck_fall) begin
      tdo_oe_next = shift_s;
      // tdo follows the fall, so half a tck separates the tdi sample at the rise from tdo
      tdo_next = chain_on ? chain_reg[0] : bypass_reg;
      if (update_s && chain_on) begin
        upd_next = chain_reg;
      end
    end
  end

  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tck_prev_reg  <= 1'b0;
      chain_reg     <= `BSDR_CHAIN_RST;
      bypass_reg    <= 1'b0;
      upd_reg       <= `BSDR_UPD_RST;
      tdo_reg       <= 1'b0;
      tdo_oe_reg    <= 1'b0;
      chain_sel_reg <= 1'b0;
    end else begin
      tck_prev_reg  <= tck_s;
      chain_reg     <= chain_next;
      bypass_reg    <= bypass_next;
      upd_reg       <= upd_next;
      tdo_reg       <= tdo_next;
      tdo_oe_reg    <= tdo_oe_next;
      chain_sel_reg <= chain_on;
    end
  end

  // bus and control pins: update latches under extest, core path otherwise
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin : bus_pins
    integer k;
    if (!I_RSTN) begin
      bus_out_reg <= {BUS_W{1'b0}};
      bus_oe_reg  <= 1'b0;
      int_n_reg   <= 1'b1;
      ack_reg     <= 1'b0;
      ack_oe_reg  <= 1'b0;
    end else if (extest_on) begin
      for (k = 0; k < BUS_W; k = k + 1) begin
        bus_out_reg[k] <= upd_reg[2*k];
      end
      bus_oe_reg <= ~upd_reg[`BSDR_POS_BUS_DIR];
      int_n_reg  <= upd_reg[`BSDR_POS_INT];
      ack_reg    <= upd_reg[`BSDR_POS_ACK];
      ack_oe_reg <= ~upd_reg[`BSDR_POS_ACK_OE];
    end else begin
      bus_out_reg <= I_CORE_BUS_OUT;
      bus_oe_reg  <= I_CORE_BUS_OE;
      int_n_reg   <= I_CORE_INT_N;
      ack_reg     <= I_CORE_ACK;
      ack_oe_reg  <= I_CORE_ACK_OE;
    end
  end

  // per-channel receive pins, one copy per channel
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_rx
      localparam integer CH_I = ch; // cut to two bits at each lookup
      reg rx_clk_reg;
      reg rx_pos_reg;
      reg rx_neg_reg;
      reg rx_oe_reg;
      reg lsig_reg;
      always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          rx_clk_reg <= 1'b0;
          rx_pos_reg <= 1'b0;
          rx_neg_reg <= 1'b0;
          rx_oe_reg  <= 1'b0;
          lsig_reg   <= 1'b0;
        end else if (extest_on) begin
          rx_clk_reg <= upd_reg[cell_pos(K_RXC, CH_I[1:0])];
          rx_pos_reg <= upd_reg[cell_pos(K_RXP, CH_I[1:0])];
          rx_neg_reg <= upd_reg[cell_pos(K_RXN, CH_I[1:0])];
          rx_oe_reg  <= ~upd_reg[cell_pos(K_RXOE, CH_I[1:0])];
          lsig_reg   <= upd_reg[cell_pos(K_LSIG, CH_I[1:0])];
        end else begin
          rx_clk_reg <= I_CORE_RX_CLK[ch];
          rx_pos_reg <= I_CORE_RX_POS[ch];
          rx_neg_reg <= I_CORE_RX_NEG[ch];
          rx_oe_reg  <= I_CORE_RX_OE[ch];
          lsig_reg   <= I_CORE_LOSS_OF_SIGNAL[ch];
        end
      end
      assign O_RX_CLK[ch]         = rx_clk_reg;
      assign O_RX_POS[ch]         = rx_pos_reg;
      assign O_RX_NEG[ch]         = rx_neg_reg;
      assign O_RX_OE[ch]          = rx_oe_reg;
      assign O_LOSS_OF_SIGNAL[ch] = lsig_reg;
    end
  endgenerate

  // outputs straight from flops
  assign O_TDO       = tdo_reg;
  assign O_TDO_OE    = tdo_oe_reg;
  assign O_CHAIN_SEL = chain_sel_reg;
  assign O_BUS_OUT   = bus_out_reg;
  assign O_BUS_OE    = bus_oe_reg;
  assign O_INT_N     = int_n_reg;
  assign O_ACK       = ack_reg;
  assign O_ACK_OE    = ack_oe_reg;

endmodule // bsdr_top

//--- tb/bsdr_chk_props.sv
`timescale 1ns/1ps

// port-level checks on the scan data path and the pin multiplexers
module bsdr_chk #(
  parameter BUS_W  = 8,
  parameter NUM_CH = 4
) (
  input wire              I_CORE_CLK,
  input wire              I_RSTN,
  input wire              I_TCK,
  input wire              I_SHIFT_DR,
  input wire              I_UPDATE_DR,
  input wire [2:0]        I_INSTR,
  input wire              O_TDO,
  input wire              O_TDO_OE,
  input wire              O_CHAIN_SEL,
  input wire [BUS_W-1:0]  I_CORE_BUS_OUT,
  input wire              I_CORE_BUS_OE,
  input wire [BUS_W-1:0]  O_BUS_OUT,
  input wire              O_BUS_OE,
  input wire [NUM_CH-1:0] I_CORE_RX_OE,
  input wire [NUM_CH-1:0] O_RX_OE,
  input wire [NUM_CH-1:0] I_CORE_LOSS_OF_SIGNAL,
  input wire [NUM_CH-1:0] O_LOSS_OF_SIGNAL,
  input wire              I_CORE_ACK_OE,
  input wire              O_ACK_OE
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);

  // six cycles leave room for the two synchroniser stages and the output flop
  sequence s_func;
    (I_INSTR != 3'h0)[*6];
  endsequence
  sequence s_quiet;
    (I_INSTR == 3'h0 && !I_UPDATE_DR)[*6];
  endsequence
  sequence s_instr_steady;
    $stable(I_INSTR)[*5];
  endsequence

  // serial output only moves a few core edges after a test clock fall
  AST_TDO_AFTER_FALL: assert property ($changed(O_TDO) |-> $past(I_TCK, 4) && !$past(I_TCK, 1))
    else $error("serial output moved away from a test clock fall");
  AST_TDO_OE_FALL: assert property ($changed(O_TDO_OE) |-> $past(I_TCK, 4) && !$past(I_TCK, 1))
    else $error("serial enable moved away from a test clock fall");
  AST_TDO_OE_SHIFT: assert property ($rose(O_TDO_OE) |-> $past(I_SHIFT_DR, 4))
    else $error("serial enable rose without shift level");
  AST_SEL_DECODE: assert property (s_instr_steady |->
    O_CHAIN_SEL == (I_INSTR == 3'h0 || I_INSTR == 3'h4))
    else $error("chain select does not match instruction");
  // outside external test the pins carry the core values one cycle later
  AST_FUNC_BUS: assert property (s_func |->
    O_BUS_OUT == $past(I_CORE_BUS_OUT) && O_BUS_OE == $past(I_CORE_BUS_OE))
    else $error("bus pins left the functional path");
  AST_FUNC_RX: assert property (s_func |-> O_RX_OE == $past(I_CORE_RX_OE)
    && O_LOSS_OF_SIGNAL == $past(I_CORE_LOSS_OF_SIGNAL))
    else $error("receive pins left the functional path");
  AST_FUNC_ACK: assert property (s_func |-> O_ACK_OE == $past(I_CORE_ACK_OE))
    else $error("acknowledge enable left the functional path");
  // latched drive values may not ripple while bits shift
  AST_HOLD_BUS: assert property (s_quiet |-> $stable(O_BUS_OUT) && $stable(O_BUS_OE))
    else $error("bus pins changed without update");
  AST_HOLD_EN: assert property (s_quiet |-> $stable(O_RX_OE) && $stable(O_ACK_OE))
    else $error("enables changed without update");
endmodule // bsdr_chk

//--- tb/bsdr_tester.sv
`timescale 1ns/1ps
`include "bsdr_defines.vh"

// boundary scan tester model; the test clock rests low between scans
module bsdr_tester (
  input  wire        i_clk,
  input  wire        i_tdo,
  output logic       o_tck,
  output logic       o_tdi,
  output logic       o_cap,
  output logic       o_shift,
  output logic       o_upd,
  output logic [2:0] o_instr
);
  initial begin
    o_tck = 1'b0;
    o_tdi = 1'b0;
    o_cap = 1'b0;
    o_shift = 1'b0;
    o_upd = 1'b0;
    o_instr = `BSDR_IR_IDCODE;
  end

  // one 160 ns period; levels settle well before the rise and hold past the fall
  task automatic tick(input logic c, s, u, d, output logic q);
    @(negedge i_clk);
    o_cap = c;
    o_shift = s;
    o_upd = u;
    o_tdi = s ? d : ~o_tdi;  // unused data line toggles so no stale bit survives
    repeat (4) @(negedge i_clk);
    q = i_tdo;
    o_tck = 1'b1;
    repeat (8) @(negedge i_clk);
    o_tck = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask

  // the instruction is chosen before any data scan
  task automatic set_ir(input logic [2:0] v);
    @(negedge i_clk);
    o_instr = v;
    repeat (8) @(negedge i_clk);
  endtask

  // capture, n shifts with sampling before each rise, then exit with optional update
  task automatic dr_scan(input logic [97:0] din, input int n, input logic u,
                         output logic [97:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, 1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(1'b0, 1'b1, 1'b0, din[i], q);
      dout[i] = q;
    end
    tick(1'b0, 1'b0, u, 1'b0, q);
    tick(1'b0, 1'b0, 1'b0, 1'b0, q);
  endtask
endmodule // bsdr_tester

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "bsdr_defines.vh"

`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", nm, e, a); end end

module tb_top;
  logic clk, rstn, tck, tdi, cap, sh, upd, tdo, tdo_oe, chain_sel, cbus_oe, bus_oe;
  logic cint_n, cack, cack_oe, int_n, ack, ack_oe, mode1, wr, rd, ale, cs;
  logic [2:0] instr;
  logic [7:0] bus_pin, cbus, bus_out;
  logic [3:0] tx_clk, tx_pos, tx_neg, crx_clk, crx_pos, crx_neg, crx_oe, closs;
  logic [3:0] rx_clk, rx_pos, rx_neg, rx_oe, loss;
  int   n_mismatch = 0;
  int   total_checks = 0;
  logic [97:0] pat_a = 98'h1_2345_6789_abcd_ef01_2345_6789;
  logic [97:0] pat_c = 98'h3_c3c3_5a5a_0ff0_1234_8765_9abc;
  // cell positions per channel: rclk, rpos, rneg, loss, tclk, tpos, tneg, rx enable
  int pos [8][4] = '{
    '{`BSDR_POS_RXC0, `BSDR_POS_RXC1, `BSDR_POS_RXC2, `BSDR_POS_RXC3},
    '{`BSDR_POS_RXP0, `BSDR_POS_RXP1, `BSDR_POS_RXP2, `BSDR_POS_RXP3},
    '{`BSDR_POS_RXN0, `BSDR_POS_RXN1, `BSDR_POS_RXN2, `BSDR_POS_RXN3},
    '{`BSDR_POS_LSIG0, `BSDR_POS_LSIG1, `BSDR_POS_LSIG2, `BSDR_POS_LSIG3},
    '{`BSDR_POS_TXC0, `BSDR_POS_TXC1, `BSDR_POS_TXC2, `BSDR_POS_TXC3},
    '{`BSDR_POS_TXP0, `BSDR_POS_TXP1, `BSDR_POS_TXP2, `BSDR_POS_TXP3},
    '{`BSDR_POS_TXN0, `BSDR_POS_TXN1, `BSDR_POS_TXN2, `BSDR_POS_TXN3},
    '{`BSDR_POS_RXOE0, `BSDR_POS_RXOE1, `BSDR_POS_RXOE2, `BSDR_POS_RXOE3}};

  bsdr_top bsdr_top_i (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_TCK(tck), .I_TDI(tdi),
    .I_CAPTURE_DR(cap), .I_SHIFT_DR(sh), .I_UPDATE_DR(upd), .I_INSTR(instr), .O_TDO(tdo),
    .O_TDO_OE(tdo_oe), .O_CHAIN_SEL(chain_sel), .I_BUS_PIN(bus_pin), .I_CORE_BUS_OUT(cbus),
    .I_CORE_BUS_OE(cbus_oe), .O_BUS_OUT(bus_out), .O_BUS_OE(bus_oe), .I_TX_CLK_PIN(tx_clk),
    .I_TX_POS_PIN(tx_pos), .I_TX_NEG_PIN(tx_neg), .I_CORE_RX_CLK(crx_clk),
    .I_CORE_RX_POS(crx_pos), .I_CORE_RX_NEG(crx_neg), .I_CORE_RX_OE(crx_oe),
    .I_CORE_LOSS_OF_SIGNAL(closs), .O_RX_CLK(rx_clk), .O_RX_POS(rx_pos), .O_RX_NEG(rx_neg),
    .O_RX_OE(rx_oe), .O_LOSS_OF_SIGNAL(loss), .I_CORE_INT_N(cint_n), .I_CORE_ACK(cack),
    .I_CORE_ACK_OE(cack_oe), .O_INT_N(int_n), .O_ACK(ack), .O_ACK_OE(ack_oe),
    .I_MODE1_PIN(mode1), .I_WR_STROBE_PIN(wr), .I_RD_STROBE_PIN(rd),
    .I_ADDR_LATCH_PIN(ale), .I_CHIP_SEL_PIN(cs));

  bsdr_tester tester_i (.i_clk(clk), .i_tdo(tdo), .o_tck(tck), .o_tdi(tdi), .o_cap(cap),
    .o_shift(sh), .o_upd(upd), .o_instr(instr));

  // image the chain should hold after capture; bus drive and enable cells keep their old bits
  function automatic logic [97:0] cap_img(input logic [97:0] prev);
    logic [97:0] m;
    m = prev;
    for (int k = 0; k < 8; k++) m[2*k+1] = bus_pin[k];
    for (int c = 0; c < 4; c++) begin
      m[pos[0][c]] = crx_clk[c];
      m[pos[1][c]] = crx_pos[c];
      m[pos[2][c]] = crx_neg[c];
      m[pos[3][c]] = closs[c];
      m[pos[4][c]] = tx_clk[c];
      m[pos[5][c]] = tx_pos[c];
      m[pos[6][c]] = tx_neg[c];
    end
    m[`BSDR_POS_MODE1] = mode1;
    m[`BSDR_POS_INT] = cint_n;
    m[`BSDR_POS_ACK] = cack;
    m[`BSDR_POS_WR] = wr;
    m[`BSDR_POS_RD] = rd;
    m[`BSDR_POS_ALE] = ale;
    m[`BSDR_POS_CS] = cs;
    return m;
  endfunction

  // pins under external test follow the updated chain image x
  task automatic check_pins(input logic [97:0] x);
    for (int k = 0; k < 8; k++) `CHK("bus_out", x[2*k], bus_out[k])
    `CHK("bus_oe", ~x[`BSDR_POS_BUS_DIR], bus_oe)
    for (int c = 0; c < 4; c++) begin
      `CHK("rx_oe", ~x[pos[7][c]], rx_oe[c])
      `CHK("rx_clk", x[pos[0][c]], rx_clk[c])
      `CHK("rx_pos", x[pos[1][c]], rx_pos[c])
      `CHK("rx_neg", x[pos[2][c]], rx_neg[c])
      `CHK("loss", x[pos[3][c]], loss[c])
    end
    `CHK("int_n", x[`BSDR_POS_INT], int_n)
    `CHK("ack", x[`BSDR_POS_ACK], ack)
    `CHK("ack_oe", ~x[`BSDR_POS_ACK_OE], ack_oe)
  endtask

  task automatic t_bypass();
    logic [97:0] q;
    tester_i.set_ir(`BSDR_IR_BYPASS);
    tester_i.dr_scan(98'hb4, 8, 1'b1, q);
    `CHK("chain_sel", 1'b0, chain_sel)
    `CHK("bypass_out", 8'h68, q[7:0])
  endtask

  // two full loads with inverted images flip every enable both ways
  task automatic t_extest();
    logic [97:0] q;
    tester_i.set_ir(`BSDR_IR_EXTEST);
    `CHK("chain_sel", 1'b1, chain_sel)
    tester_i.dr_scan(pat_a, 98, 1'b1, q);
    `CHK("capture", cap_img(98'h0), q)
    check_pins(pat_a);
    tester_i.dr_scan(~pat_a, 98, 1'b1, q);
    `CHK("capture", cap_img(pat_a), q)
    check_pins(~pat_a);
  endtask

  task automatic t_sample();
    logic [97:0] q;
    @(negedge clk);
    cbus = 8'hc3;
    bus_pin = 8'h69;  // fresh sensed levels on bits 2, 3, 6 and 7, so a stale capture cell there cannot pass
    tester_i.set_ir(`BSDR_IR_SAMPLE);
    tester_i.dr_scan(pat_c, 98, 1'b1, q);
    `CHK("capture", cap_img(~pat_a), q)
    `CHK("bus_out", 8'hc3, bus_out)
    `CHK("int_n", cint_n, int_n)
    `CHK("rx_clk", crx_clk, rx_clk)
    `CHK("rx_pos", crx_pos, rx_pos)
  endtask

  // mid-run reset under external test: latches float every pin, chain comes back clear
  task automatic t_reset();
    logic [97:0] q;
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("rst_chain_sel", 1'b0, chain_sel)
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check_pins({98{1'b1}});
    tester_i.dr_scan(pat_c, 98, 1'b0, q);
    `CHK("capture", cap_img(98'h0), q)
    `CHK("chain_sel", 1'b1, chain_sel)
  endtask

  // identification scan with update must leave chain and latches alone
  task automatic t_refused();
    logic [97:0] q;
    tester_i.set_ir(`BSDR_IR_IDCODE);
    tester_i.dr_scan(pat_a, 98, 1'b1, q);
    tester_i.set_ir(`BSDR_IR_EXTEST);
    check_pins(pat_c);
    tester_i.dr_scan(pat_a, 98, 1'b1, q);
    `CHK("capture", cap_img(pat_c), q)
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    bus_pin = 8'ha5;
    cbus = 8'h3c;
    cbus_oe = 1'b1;
    {tx_clk, tx_pos, tx_neg} = 12'h5a3;
    {crx_clk, crx_pos, crx_neg, crx_oe, closs} = 20'h6_9cf2;
    {cint_n, cack, cack_oe, mode1, wr, rd, ale, cs} = 8'h5b;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_bypass();
    t_extest();
    t_sample();
    t_refused();
    t_reset();
    tally_and_finish();
  end

  // hang guard, well beyond the six full scans
  initial begin
    #500_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb_top

bind bsdr_top bsdr_chk #(.BUS_W(BUS_W), .NUM_CH(NUM_CH)) bsdr_chk_i (.I_CORE_CLK, .I_RSTN,
  .I_TCK, .I_SHIFT_DR, .I_UPDATE_DR, .I_INSTR, .O_TDO, .O_TDO_OE, .O_CHAIN_SEL,
  .I_CORE_BUS_OUT, .I_CORE_BUS_OE, .O_BUS_OUT, .O_BUS_OE, .I_CORE_RX_OE, .O_RX_OE,
  .I_CORE_LOSS_OF_SIGNAL, .O_LOSS_OF_SIGNAL, .I_CORE_ACK_OE, .O_ACK_OE);
